// file: hdl/vatc_top.sv
// Actuator motor control: limit and torque switch handling per variant,
// run and start time supervision, fault lockout, Avalon-MM registers.
// Assumes switch inputs are asynchronous pins and the bus is on i_ref_clk.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "vatc_consts.svh"
`default_nettype none
module vatc_top #(
    parameter int unsigned MS_CYCLES = `VATC_MS_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_open_limit_in,
    input wire logic i_closed_limit_in,
    input wire logic i_torque_midpoint_in,
    input wire logic i_torque_loop_in,
    output logic o_motor_open,
    output logic o_motor_close,
    output logic o_aux_relay_out,
    output logic o_aux_supply_fault_out,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage feeds only the second
    // No reset, so the power-up torque check sees the settled pins
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge i_ref_clk) begin
        sync_a <= {i_torque_loop_in, i_torque_midpoint_in,
                   i_closed_limit_in, i_open_limit_in};
        sync_b <= sync_a;
    end
    logic lim_open; // Active high limit
    logic lim_closed;
    logic tq_ok; // Closed loop: low means tripped
    logic tq_mid;
    assign lim_open = sync_b[0]; // RULE9
    assign lim_closed = sync_b[1]; // RULE9
    assign tq_mid = sync_b[2];
    assign tq_ok = sync_b[3]; // RULE9

    ////////////////////////////////////////////////////////////////////
    // Millisecond tick from a divider
    logic [16:0] div_cnt;
    logic ms_tick;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            div_cnt <= 17'h0;
            ms_tick <= 1'b0;
        end else if (div_cnt == 17'(MS_CYCLES - 1)) begin
            div_cnt <= 17'h0;
            ms_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 17'h1;
            ms_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers written by software
    logic [1:0] variant; // Variant select
    logic aux_sel; // 0: aux supply output, 1: relay output
    logic flt_out_en; // Fault indication enable
    logic [15:0] run_ms; // Run-time limit in ms
    logic [15:0] start_ms; // Start monitoring time in ms
    logic [3:0] irq_mask;
    logic cmd_open_p; // One-cycle command pulses
    logic cmd_close_p;
    logic cmd_stop_p;
    logic cmd_reset_p;
    logic [3:0] irq_stat;
    logic [3:0] ev; // Event pulses from the control logic
    logic wr_ok;
    logic rd_ok;
    // One wait cycle so every answer leaves a flip-flop
    assign wr_ok = i_avs_write && !o_avs_waitrequest;
    assign rd_ok = i_avs_read && !o_avs_waitrequest;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_avs_waitrequest <= 1'b1;
        end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end
    // Configuration and command decode
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            variant <= `VATC_VARIANT_RST;
            aux_sel <= 1'b0;
            flt_out_en <= 1'b0;
            run_ms <= 16'(`VATC_RUN_MS_DEF);
            start_ms <= 16'(`VATC_START_MS_DEF);
            irq_mask <= 4'h0;
            cmd_open_p <= 1'b0;
            cmd_close_p <= 1'b0;
            cmd_stop_p <= 1'b0;
            cmd_reset_p <= 1'b0;
        end else begin
            cmd_open_p <= 1'b0;
            cmd_close_p <= 1'b0;
            cmd_stop_p <= 1'b0;
            cmd_reset_p <= 1'b0;
            if (wr_ok) begin
                case ({i_avs_address[4:2], 2'b00})
                    5'(`VATC_REG_CTRL): begin
                        variant <= i_avs_writedata[1:0];
                        aux_sel <= i_avs_writedata[`VATC_CTRL_AUXSEL];
                        flt_out_en <= i_avs_writedata[`VATC_CTRL_FLTOUT];
                    end
                    5'(`VATC_REG_CMD): begin
                        cmd_close_p <= i_avs_writedata[`VATC_CMD_CLOSE];
                        cmd_stop_p <= i_avs_writedata[`VATC_CMD_STOP];
                        cmd_open_p <= i_avs_writedata[`VATC_CMD_OPEN];
                        cmd_reset_p <= i_avs_writedata[`VATC_CMD_RESET];
                    end
                    5'(`VATC_REG_MASK): irq_mask <= i_avs_writedata[3:0];
                    5'(`VATC_REG_RUNT): run_ms <= i_avs_writedata[15:0];
                    5'(`VATC_REG_STRT): start_ms <= i_avs_writedata[15:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Motion control state
    vatc_pkg::vatc_state_t state;
    logic fault; // Internal fault flag
    logic armed; // Pending stop prepared by a limit
    logic blk_open; // Opening not permitted
    logic blk_close; // Closing not permitted
    logic last_dir_open; // Direction before the last stop
    logic tq_open_flag; // Torque tripped in open direction
    logic tq_close_flag;
    logic heal_on; // Torque must heal after restart
    logic [15:0] run_cnt;
    logic [15:0] start_cnt;
    logic [9:0] heal_cnt;
    logic start_on; // Departing limit being watched
    logic por_done; // Power-up check taken
    logic v1;
    logic open_stops; // Open limit stops directly
    logic closed_stops;
    logic tq_stops_open; // Torque ends opening travel
    logic tq_stops_close;
    assign v1 = (variant == vatc_pkg::VATC_V1);
    assign open_stops = v1 || (variant == vatc_pkg::VATC_V3);
    assign closed_stops = v1 || (variant == vatc_pkg::VATC_V4);
    assign tq_stops_open = (variant == vatc_pkg::VATC_V2) ||
                           (variant == vatc_pkg::VATC_V4);
    assign tq_stops_close = (variant == vatc_pkg::VATC_V2) ||
                            (variant == vatc_pkg::VATC_V3);
    logic moving;
    logic trip;
    assign moving = (state != vatc_pkg::VATC_IDLE);
    // Trip ignored while torque heal window runs after restart
    assign trip = moving && !tq_ok && !heal_on;
    logic lim_hit;
    logic arm_hit;
    logic tq_fault;
    logic tq_end;
    logic run_over;
    logic start_over;
    logic heal_over;
    always_comb begin
        lim_hit = 1'b0;
        arm_hit = 1'b0;
        tq_fault = 1'b0;
        tq_end = 1'b0;
        if (state == vatc_pkg::VATC_OPENING) begin
            lim_hit = lim_open && open_stops && !start_on; // RULE1 RULE5
            arm_hit = lim_open && !open_stops; // RULE3 RULE6
            // Variant 1 treats every trip as fault
            tq_end = trip && armed && tq_stops_open && !v1;
        end else if (state == vatc_pkg::VATC_CLOSING) begin
            lim_hit = lim_closed && closed_stops && !start_on; // RULE1 RULE6
            arm_hit = lim_closed && !closed_stops; // RULE3 RULE5
            // Variant 4 closing: torque always a fault
            tq_end = trip && armed && tq_stops_close && !v1; // RULE7
        end
        tq_fault = trip && !tq_end; // RULE2 RULE4 RULE7
    end
    assign run_over = moving && (run_ms != 16'(`VATC_RUN_OFF_MS)) &&
                      (run_cnt >= run_ms); // RULE10
    assign start_over = start_on && (start_cnt >= start_ms); // RULE11
    assign heal_over = heal_on && !tq_ok &&
                       (heal_cnt >= 10'(`VATC_HEAL_MS)); // RULE13
    logic go_open;
    logic go_close;
    // Start only without fault and not toward the blocked side
    assign go_open = cmd_open_p && !fault && !blk_open && !cmd_stop_p;
    assign go_close = cmd_close_p && !fault && !blk_close && !cmd_stop_p;
    logic halt;
    assign halt = cmd_stop_p || lim_hit || tq_end || tq_fault ||
                  run_over || start_over || heal_over;

    // State machine and lockout bookkeeping
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state <= vatc_pkg::VATC_IDLE;
            fault <= 1'b0;
            armed <= 1'b0;
            blk_open <= 1'b0;
            blk_close <= 1'b0;
            last_dir_open <= 1'b0;
            por_done <= 1'b0;
        end else begin
            if (!por_done) begin
                por_done <= 1'b1;
                // Trip at power-up mid-travel: assume closing
                if (!tq_ok && !lim_open && !lim_closed) begin
                    fault <= 1'b1; // RULE14
                    blk_close <= 1'b1; // RULE14
                    last_dir_open <= 1'b0;
                end
            end
            if (arm_hit) begin
                armed <= 1'b1;
            end
            case (state)
                vatc_pkg::VATC_IDLE: begin
                    if (cmd_reset_p) begin
                        fault <= 1'b0; // RULE12
                    end else if (go_open) begin
                        state <= vatc_pkg::VATC_OPENING;
                        blk_close <= 1'b0;
                        armed <= 1'b0;
                    end else if (go_close) begin
                        state <= vatc_pkg::VATC_CLOSING;
                        blk_open <= 1'b0;
                        armed <= 1'b0;
                    end
                end
                vatc_pkg::VATC_OPENING, vatc_pkg::VATC_CLOSING: begin
                    // Reversal request only stops; no direct swap
                    if (halt || cmd_open_p || cmd_close_p) begin // RULE19
                        state <= vatc_pkg::VATC_IDLE;
                        last_dir_open <= (state == vatc_pkg::VATC_OPENING);
                        armed <= 1'b0;
                        if (tq_fault || start_over || run_over ||
                            heal_over) begin
                            fault <= 1'b1; // RULE4 RULE13
                        end
                        // Block the direction just used at an end or trip
                        if (lim_hit || tq_end || tq_fault || heal_over) begin
                            if (state == vatc_pkg::VATC_OPENING) begin
                                blk_open <= 1'b1; // RULE1 RULE3 RULE12
                            end else begin
                                blk_close <= 1'b1; // RULE1 RULE3 RULE12
                            end
                        end
                    end
                end
                default: state <= vatc_pkg::VATC_IDLE;
            endcase
        end
    end

    // Supervision timers in milliseconds
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            run_cnt <= 16'h0;
            start_cnt <= 16'h0;
            heal_cnt <= 10'h0;
            start_on <= 1'b0;
            heal_on <= 1'b0;
        end else if (state == vatc_pkg::VATC_IDLE) begin
            run_cnt <= 16'h0;
            start_cnt <= 16'h0;
            heal_cnt <= 10'h0;
            // Watch departure when starting from an end position
            start_on <= (go_open && lim_closed) || (go_close && lim_open);
            // Restarting on a tripped loop opens the heal window
            heal_on <= (go_open || go_close) && !tq_ok;
        end else begin
            if (ms_tick && run_cnt != 16'hFFFF) begin
                run_cnt <= run_cnt + 16'h1;
            end
            if (start_on) begin
                if ((state == vatc_pkg::VATC_OPENING && !lim_closed) ||
                    (state == vatc_pkg::VATC_CLOSING && !lim_open)) begin
                    start_on <= 1'b0; // RULE11
                end else if (ms_tick) begin
                    start_cnt <= start_cnt + 16'h1;
                end
            end
            if (heal_on) begin
                if (tq_ok) begin
                    heal_on <= 1'b0; // RULE13
                end else if (ms_tick) begin
                    heal_cnt <= heal_cnt + 10'h1;
                end
            end
        end
    end

    // Torque direction flags from last movement only; midpoint is not used
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tq_open_flag <= 1'b0;
            tq_close_flag <= 1'b0;
        end else if (tq_ok) begin
            tq_open_flag <= 1'b0;
            tq_close_flag <= 1'b0;
        end else if (state == vatc_pkg::VATC_IDLE) begin
            tq_open_flag <= last_dir_open; // RULE8
            tq_close_flag <= !last_dir_open; // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over write-one clear
    assign ev[`VATC_EV_FAULT] = moving && (tq_fault || start_over ||
                                run_over || heal_over);
    assign ev[`VATC_EV_TQOPEN] = tq_end && state == vatc_pkg::VATC_OPENING;
    assign ev[`VATC_EV_TQCLOSE] = tq_end && state == vatc_pkg::VATC_CLOSING;
    assign ev[`VATC_EV_ENDPOS] = lim_hit;
    logic clr_hit;
    assign clr_hit = wr_ok && ({i_avs_address[4:2], 2'b00} ==
                     5'(`VATC_REG_IRQ));
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            irq_stat <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~(clr_hit ? i_avs_writedata[3:0] : 4'h0))
                        | ev;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_motor_open <= 1'b0;
            o_motor_close <= 1'b0;
            o_aux_relay_out <= 1'b0;
            o_aux_supply_fault_out <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            // One-hot state keeps the two contactors exclusive
            o_motor_open <= (state == vatc_pkg::VATC_OPENING) && !halt; // RULE19
            o_motor_close <= (state == vatc_pkg::VATC_CLOSING) && !halt;
            o_aux_relay_out <= flt_out_en && aux_sel && fault; // RULE17
            o_aux_supply_fault_out <= flt_out_en && !aux_sel && fault; // RULE17
            o_irq <= |(irq_stat & irq_mask);
        end
    end
    // Read data; checkback and dip handling not present // RULE15
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h0;
        end else if (rd_ok || !o_avs_waitrequest) begin
            o_avs_readdata <= 32'h0;
        end else if (i_avs_read) begin
            case ({i_avs_address[4:2], 2'b00})
                5'(`VATC_REG_CTRL): o_avs_readdata <= {26'h0, flt_out_en,
                                    aux_sel, 2'h0, variant};
                5'(`VATC_REG_STAT): o_avs_readdata <= {20'h0, tq_mid, tq_ok,
                                    lim_closed, lim_open, tq_close_flag,
                                    tq_open_flag, blk_close, blk_open,
                                    armed, fault, state[2], state[1]};
                5'(`VATC_REG_IRQ): o_avs_readdata <= {28'h0, irq_stat};
                5'(`VATC_REG_MASK): o_avs_readdata <= {28'h0, irq_mask};
                5'(`VATC_REG_RUNT): o_avs_readdata <= {16'h0, run_ms};
                5'(`VATC_REG_STRT): o_avs_readdata <= {16'h0, start_ms};
                default: o_avs_readdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    a_dir_exclusive: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !(o_motor_open && o_motor_close))
        else $error("both directions driven"); // RULE19
    a_fault_blocks_start: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (fault && state == vatc_pkg::VATC_IDLE && !cmd_reset_p) |=> !moving)
        else $error("start while faulted"); // RULE12
    a_tq_fault_sets: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) tq_fault |=> fault && !moving)
        else $error("torque fault not latched"); // RULE4
    a_limit_stops: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) lim_hit |=> !moving ##1 !o_motor_open)
        else $error("limit did not stop"); // RULE1
    a_open_blocked: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (state == vatc_pkg::VATC_OPENING && (lim_hit || tq_end)) |=> blk_open)
        else $error("open not blocked"); // RULE3
    a_v4_close_trip: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (variant == vatc_pkg::VATC_V4 && state == vatc_pkg::VATC_CLOSING
         && trip) |=> fault)
        else $error("closing trip not fault"); // RULE7
    a_start_timeout: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) start_over |=> fault)
        else $error("start timeout no fault"); // RULE11
    a_heal_timeout: assert property (@(posedge i_ref_clk)
        disable iff (i_reset) heal_over |=> fault && blk_open | blk_close)
        else $error("heal timeout no fault"); // RULE13
    a_run_disable: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (run_ms == 16'(`VATC_RUN_OFF_MS)) |-> !run_over)
        else $error("run limit not disabled"); // RULE10
endmodule : vatc_top
`default_nettype wire

// file: hdl/vatc_consts.svh
// Constants for the valve actuator limit and torque control block.
// Assumes a 125 MHz reference clock and an Avalon-MM register master.
// How it works
// RULE1: Variant 1: limits stop, restart only away.
// RULE2: Variant 1: torque loop loss is fault, stop.
// RULE3: Variant 2: limits arm, torque stops, reverse only.
// RULE4: Unarmed torque trip mid-travel sets fault, stops.
// RULE5: Variant 3: open stops, closed arms, torque stops.
// RULE6: Variant 4: closed stops, open arms, torque stops.
// RULE7: Variant 4: torque while closing is fault.
// RULE8: Report torque-open/closed from last direction.
// RULE9: Limits active high; torque low means tripped.
// RULE10: Run-time supervision; limit 1 s disables it.
// RULE11: Departing limit must release within start time.
// RULE12: After torque fault: reset, then opposite only.
// RULE13: Torque must heal within 0.5 s after restart.
// RULE14: Power-up trip mid-travel: assume closing, open only.
// RULE15: No dip handling, no input checkback.
// RULE16: Configuring party sets inputs and time limit.
// RULE17: Optional fault on aux supply or relay output.
// RULE18: Installer may wire midpoint input for identity.
// RULE19: Never both directions; stop before reversal.
`ifndef VATC_CONSTS_SVH
`define VATC_CONSTS_SVH
`define VATC_CLK_HZ 125000000
`define VATC_MS_CYCLES (`VATC_CLK_HZ / 1000)
`define VATC_HEAL_MS 500
`define VATC_START_MS_DEF 3000
`define VATC_RUN_MS_DEF 60000
`define VATC_RUN_OFF_MS 1000
`define VATC_REG_CTRL 5'h00
`define VATC_REG_CMD 5'h04
`define VATC_REG_STAT 5'h08
`define VATC_REG_IRQ 5'h0C
`define VATC_REG_MASK 5'h10
`define VATC_REG_RUNT 5'h14
`define VATC_REG_STRT 5'h18
`define VATC_VARIANT_RST 2'h1
`define VATC_CMD_CLOSE 0
`define VATC_CMD_STOP 1
`define VATC_CMD_OPEN 2
`define VATC_CMD_RESET 6
`define VATC_CTRL_AUXSEL 4
`define VATC_CTRL_FLTOUT 5
`define VATC_EV_FAULT 0
`define VATC_EV_TQOPEN 1
`define VATC_EV_TQCLOSE 2
`define VATC_EV_ENDPOS 3
`endif

// file: hdl/vatc_pkg.sv
// Types for the valve actuator limit and torque control block.
// Assumes the constants header is included alongside.
package vatc_pkg;
    // Motion states, one-hot
    typedef enum logic [2:0] {
        VATC_IDLE = 3'b001,
        VATC_OPENING = 3'b010,
        VATC_CLOSING = 3'b100
    } vatc_state_t;
    // Variant selection
    typedef enum logic [1:0] {
        VATC_V1 = 2'h0,
        VATC_V2 = 2'h1,
        VATC_V3 = 2'h2,
        VATC_V4 = 2'h3
    } vatc_variant_t;
endpackage : vatc_pkg

// file: testbench/vatc_valve_model.sv
// Behavioural valve: travel, two limit switches, series torque loop.
// Assumes the block's motor outputs drive it, one step per clock.
`timescale 1ns/10ps
`default_nettype none
module vatc_valve_model #(
    parameter int TOP = 40
) (
    input wire logic i_ref_clk,
    input wire logic i_motor_open,
    input wire logic i_motor_close,
    input wire logic i_jam,
    output logic o_open_limit,
    output logic o_closed_limit,
    output logic o_torque_loop,
    output logic o_midpoint
);
    int pos = 20; // Starts between end positions
    // Travel while energised; hard stops at both ends
    always @(posedge i_ref_clk) begin
        if (i_motor_open && pos < TOP) begin
            pos <= pos + 1;
        end else if (i_motor_close && pos > 0) begin
            pos <= pos - 1;
        end
    end
    // Limits are active high well before the hard stops
    assign o_open_limit = (pos >= TOP - 8);
    assign o_closed_limit = (pos <= 8);
    // Loop stays open while pressed on a stop, so restart must heal it
    assign o_torque_loop = !(i_jam || pos == 0 || pos == TOP);
    // Junction tap: low only when the closed-side contact tripped
    assign o_midpoint = (pos != 0);
endmodule : vatc_valve_model
`default_nettype wire

// file: testbench/testbench.sv
// Bench for the actuator control block: bus tasks and scenarios.
// Assumes the valve model file; ms tick shortened to 10 cycles.
`timescale 1ns/10ps
`include "vatc_consts.svh"
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, q;
    logic wreq, ol, cl, tq, mp, mo, mc, relay, supply, irq;
    logic jam = 1'b1; // Loop tripped at power-up, mid travel
    int n_mismatch = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    vatc_top #(.MS_CYCLES(10)) i_dut (.i_ref_clk(clk), .i_reset(rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_open_limit_in(ol),
        .i_closed_limit_in(cl), .i_torque_midpoint_in(mp),
        .i_torque_loop_in(tq), .o_motor_open(mo), .o_motor_close(mc),
        .o_aux_relay_out(relay), .o_aux_supply_fault_out(supply),
        .o_irq(irq));
    vatc_valve_model i_valve (.i_ref_clk(clk), .i_motor_open(mo),
        .i_motor_close(mc), .i_jam(jam), .o_open_limit(ol),
        .o_closed_limit(cl), .o_torque_loop(tq), .o_midpoint(mp));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // One Avalon-MM access, held until waitrequest is seen low
    // Only the watchdog bounds the wait
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // Command pulses are one-hot bits of the command word
    task automatic cmd(input int b);
        bus(1'b1, 5'(`VATC_REG_CMD), 32'h1 << b);
    endtask : cmd
    // Waits, bounded, for the wanted pair of direction outputs
    task automatic motor(input logic o, input logic c);
        int n;
        n = 0;
        while ((mo !== o || mc !== c) && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk({30'h0, mo, mc}, {30'h0, o, c});
    endtask : motor
    // A refused start leaves both outputs off past the 3-cycle latency
    task automatic refused(input int b);
        cmd(b);
        repeat (6) @(posedge clk);
        chk({30'h0, mo, mc}, 32'h0);
    endtask : refused
    ////////////////////////////////////////////////////////////////////
    task automatic power_up();
        chk({mo, mc, irq}, 3'h0);
        bus(1'b0, 5'(`VATC_REG_CTRL), 32'h0);
        chk(q, 32'h1);
        bus(1'b0, 5'h1C, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 5'(`VATC_REG_STAT), 32'h0);
        chk({q[5], q[2]}, 2'h3);
        refused(`VATC_CMD_OPEN);
        jam <= 1'b0;
        cmd(`VATC_CMD_RESET);
        refused(`VATC_CMD_CLOSE);
        cmd(`VATC_CMD_OPEN);
        motor(1'b1, 1'b0);
    endtask : power_up
    // Variant 2: open limit only arms, torque at the stop ends travel
    task automatic v2_open_end();
        motor(1'b0, 1'b0);
        chk({31'h0, tq}, 32'h0);
        bus(1'b0, 5'(`VATC_REG_STAT), 32'h0);
        chk({q[7], q[6], q[2]}, 3'h2);
        refused(`VATC_CMD_OPEN);
        cmd(`VATC_CMD_CLOSE);
        motor(1'b0, 1'b1);
        cmd(`VATC_CMD_OPEN);
        motor(1'b0, 1'b0);
    endtask : v2_open_end
    // Variant 1: closed limit stops before the torque stop is reached
    task automatic v1_closed_end();
        bus(1'b1, 5'(`VATC_REG_CTRL), 32'h0);
        cmd(`VATC_CMD_CLOSE);
        motor(1'b0, 1'b1);
        motor(1'b0, 1'b0);
        chk({tq, cl}, 2'h3);
        refused(`VATC_CMD_CLOSE);
    endtask : v1_closed_end
    // Variant 1 jam mid travel, fault output, masked interrupt, W1C
    task automatic jam_fault();
        bus(1'b1, 5'(`VATC_REG_CTRL), 32'h20);
        bus(1'b1, 5'h10, 32'h0);
        cmd(`VATC_CMD_OPEN);
        motor(1'b1, 1'b0);
        repeat (6) @(posedge clk);
        jam <= 1'b1;
        motor(1'b0, 1'b0);
        bus(1'b0, 5'(`VATC_REG_STAT), 32'h0);
        chk({31'h0, q[2]}, 32'h1);
        chk({supply, relay, irq}, 3'h4);
        bus(1'b1, 5'h10, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 5'(`VATC_REG_IRQ), 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        jam <= 1'b0;
        cmd(`VATC_CMD_RESET);
        refused(`VATC_CMD_OPEN);
        cmd(`VATC_CMD_CLOSE);
        motor(1'b0, 1'b1);
    endtask : jam_fault
    // Stop command, variant 4 open end by torque, closing trip faults
    task automatic v4_ends();
        cmd(`VATC_CMD_STOP);
        motor(1'b0, 1'b0);
        bus(1'b0, 5'(`VATC_REG_STAT), 32'h0);
        chk({q[5], q[4], q[2]}, 3'h0);
        bus(1'b1, 5'(`VATC_REG_CTRL), 32'h33);
        cmd(`VATC_CMD_OPEN);
        motor(1'b1, 1'b0);
        motor(1'b0, 1'b0);
        bus(1'b0, 5'(`VATC_REG_STAT), 32'h0);
        chk({q[4], q[3], q[2]}, 3'h4);
        cmd(`VATC_CMD_CLOSE);
        motor(1'b0, 1'b1);
        repeat (6) @(posedge clk);
        jam <= 1'b1;
        motor(1'b0, 1'b0);
        bus(1'b0, 5'(`VATC_REG_STAT), 32'h0);
        chk({q[5], q[2]}, 2'h3);
        chk({relay, supply, irq}, 3'h5);
    endtask : v4_ends
    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // Both directions at once is never acceptable
    always @(posedge clk) begin
        if (mo === 1'b1 && mc === 1'b1) begin
            chk(32'h1, 32'h0);
        end
    end
    // Whole run is a few hundred cycles; this is ample margin
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk);
        chk({31'h0, wreq}, 32'h1);
        rst <= 1'b0;
        power_up();
        v2_open_end();
        v1_closed_end();
        jam_fault();
        v4_ends();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
